// file: dv/lhkce_chk_properties.sv
// port assertions of the limp-home key code entry block
`timescale 1ns/1ps
`default_nettype none
`include "lhkce_cfg.svh"

module lhkce_chk #(
  parameter int TICK_CYC = `LHKCE_TICK_CYC,
  parameter int ENABLE_TK = `LHKCE_T_ENABLE_MS / `LHKCE_TICK_MS
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // inputs
  input wire logic ign_on,
  input wire logic variant_sa,
  input wire logic ecu_learnt,
  input wire logic ecu_virgin,
  input wire logic pwd_learnt,
  input wire logic nd_valid,
  input wire logic nd_ok,
  input wire logic [`LHKCE_NFLT-1:0] flt_ev,
  input wire logic [1:0] flt_type,
  // outputs
  input wire logic entry_active,
  input wire logic start_ok,
  input wire logic unlock_active,
  input wire logic lockout_active,
  input wire logic nd_req,
  input wire logic neutral,
  input wire logic teach_virgin_ok,
  input wire logic twice_on_ok,
  input wire logic dtc_stb,
  input wire logic [15:0] dtc_code,
  input wire logic [1:0] dtc_type
);
  localparam logic [31:0] MIN_ON = 32'((ENABLE_TK - 1) * TICK_CYC);
  logic [31:0] on_cnt_ff;

  // clock-enabled cycles the ignition pin has been on without a break
  always_ff @(posedge clk) begin
    if (srst || !ign_on) begin
      on_cnt_ff <= 32'h0;
    end else if (ce && on_cnt_ff != 32'hffffffff) begin
      on_cnt_ff <= on_cnt_ff + 32'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_report0;
    ##2 dtc_stb && dtc_code == (variant_sa ? `LHKCE_DTC_UNTAUGHT : `LHKCE_DTC_BCM_COMM);
  endsequence
  sequence s_type0;
    ##2 dtc_type == $past(flt_type, 2);
  endsequence

  property p_fault0;
    flt_ev[0] |-> s_report0 and s_type0;
  endproperty
  property p_code_hold;
    !dtc_stb |-> $stable(dtc_code) && $stable(dtc_type);
  endproperty
  property p_entry_on;
    $rose(entry_active) |-> on_cnt_ff >= MIN_ON;
  endproperty
  property p_unlock_start;
    $rose(unlock_active) |=> start_ok;
  endproperty
  property p_unlock_learnt;
    $rose(unlock_active) |-> $past(ecu_learnt) && $past(pwd_learnt);
  endproperty
  property p_sa_lock;
    variant_sa && $fell(ign_on) |-> ##[1:5] !unlock_active;
  endproperty
  property p_neutral;
    neutral |-> !entry_active && !twice_on_ok;
  endproperty
  property p_nd_ans;
    nd_req && nd_valid && nd_ok |=> neutral && !nd_req;
  endproperty
  property p_teach;
    teach_virgin_ok == (ecu_virgin || neutral);
  endproperty
  property p_lock_entry;
    lockout_active |-> !$rose(entry_active);
  endproperty

  a_fault0: assert property (p_fault0)
    else $error("first fault source not reported");
  a_code_hold: assert property (p_code_hold)
    else $error("fault code changed without strobe");
  a_entry_on: assert property (p_entry_on)
    else $error("entry enabled too early");
  a_unlock_start: assert property (p_unlock_start)
    else $error("unlock without start permission");
  a_unlock_learnt: assert property (p_unlock_learnt)
    else $error("unlock while not learnt");
  a_sa_lock: assert property (p_sa_lock)
    else $error("stand-alone not locked on ignition off");
  a_neutral: assert property (p_neutral)
    else $error("neutral unit accepts entry or start");
  a_nd_ans: assert property (p_nd_ans)
    else $error("neutral not entered on good data");
  a_teach: assert property (p_teach)
    else $error("teach permission wrong");
  a_lock_entry: assert property (p_lock_entry)
    else $error("entry enabled during refusal hour");
endmodule : lhkce_chk

bind lhkce_core lhkce_chk #(.TICK_CYC(TICK_CYC), .ENABLE_TK(ENABLE_TK)) lhkce_chk_i (
  .clk, .srst, .ce, .ign_on, .variant_sa, .ecu_learnt, .ecu_virgin, .pwd_learnt,
  .nd_valid, .nd_ok, .flt_ev, .flt_type, .entry_active, .start_ok, .unlock_active,
  .lockout_active, .nd_req, .neutral, .teach_virgin_ok, .twice_on_ok, .dtc_stb,
  .dtc_code, .dtc_type);
`default_nettype wire

// file: dv/lhkce_partner.sv
// ignition switch and service tester model
`timescale 1ns/1ps
`default_nettype none

module lhkce_partner (
  // clocking
  input wire logic clk,
  // request from the unit
  input wire logic nd_req,
  // switch and tester
  output logic ign_on,
  output logic nd_valid,
  output logic nd_ok
);
  logic good_data;
  int lag;

  initial begin
    ign_on = 1'b0;
    nd_valid = 1'b0;
    nd_ok = 1'b0;
    good_data = 1'b1;
    lag = 3;
  end

  task automatic hold(input logic lvl, input int n);
    ign_on = lvl;
    repeat (n) @(posedge clk);
    #2;
  endtask : hold

  // one digit as on/off cycles, then a long off closes it
  task automatic digit(input logic [3:0] d);
    repeat ((d == 4'h0) ? 10 : int'(d)) begin
      hold(1'b1, 4);
      hold(1'b0, 4);
    end
    hold(1'b0, 20);
  endtask : digit

  task automatic send_pwd(input logic [15:0] p);
    for (int i = 3; i >= 0; i--) begin
      digit(p[i*4 +: 4]);
    end
  endtask : send_pwd

  // tester answers a vehicle data request
  always @(posedge clk) begin
    if (nd_req === 1'b1 && !nd_valid) begin
      repeat (lag) @(posedge clk);
      #2;
      nd_valid = 1'b1;
      nd_ok = good_data;
      @(posedge clk);
      #2;
      nd_valid = 1'b0;
      nd_ok = ~nd_ok;
    end
  end
endmodule : lhkce_partner
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the limp-home key code entry block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, srst, ce, variant_sa, ecu_learnt, ecu_virgin, pwd_learnt, nv_lockout;
  logic key_valid, neut_cmd, teach_done, twice_on_req, data_try_fail, data_try_ok;
  logic ign_on, nd_valid, nd_ok, entry_active, start_ok, unlock_active, lockout_active;
  logic nd_req, neutral, teach_virgin_ok, twice_on_ok, dtc_stb;
  logic [15:0] stored_pwd, pwd, dtc_code;
  logic [5:0] flt_ev;
  logic [1:0] flt_type, dtc_type;
  int seed, error_cnt, samples_checked, stb_cnt, k;

  lhkce_core #(.TICK_CYC(4), .ENABLE_TK(5), .DIGIT_TK(3), .ABORT_TK(10), .UNLOCK_TK(30),
    .RELOCK_TK(8), .LOCKOUT_TK(20)) lhkce_core_i (.clk, .srst, .ce, .ign_on, .variant_sa,
    .ecu_learnt, .ecu_virgin, .pwd_learnt, .stored_pwd, .nv_lockout, .key_valid, .neut_cmd,
    .nd_valid, .nd_ok, .teach_done, .twice_on_req, .flt_ev, .flt_type, .data_try_fail,
    .data_try_ok, .entry_active, .start_ok, .unlock_active, .lockout_active, .nd_req,
    .neutral, .teach_virgin_ok, .twice_on_ok, .dtc_stb, .dtc_code, .dtc_type);
  lhkce_partner lhkce_partner_i (.clk, .nd_req, .ign_on, .nd_valid, .nd_ok);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dtc_stb === 1'b1) stb_cnt++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic ign(input logic lvl, input int n);
    lhkce_partner_i.hold(lvl, n);
  endtask : ign

  task automatic enter(input logic [15:0] p);
    ign(1'b0, 24);
    ign(1'b1, 32);
    lhkce_partner_i.send_pwd(p);
  endtask : enter

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] rnd_pwd();
    logic [15:0] p;
    for (int i = 0; i < 4; i++) p[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
    return p;
  endfunction : rnd_pwd

  function automatic logic [15:0] exp_code(input logic sa, input int i);
    logic [15:0] tbl [0:5];
    tbl = '{16'h1610, 16'h1800, 16'h1803, 16'h1801, 16'h1801, 16'h1805};
    return sa ? 16'(i + 1) : tbl[i];
  endfunction : exp_code

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(25 * 20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    seed = 32'h73d9;
    {srst, ce, ecu_learnt, pwd_learnt} = 4'hf;
    {variant_sa, nv_lockout, key_valid, neut_cmd, teach_done} = 5'h00;
    {twice_on_req, data_try_fail, data_try_ok, flt_ev, flt_type} = 11'h000;
    ecu_virgin = 1'($random(seed));
    pwd = rnd_pwd();
    pwd[3:0] = 4'h0;
    stored_pwd = pwd;
    tick(16);
    srst = 1'b0;
    ign(1'b1, 14);
    chk("entry", entry_active, 0);
    ign(1'b1, 18);
    chk("entry", entry_active, 1);
    lhkce_partner_i.send_pwd(pwd);
    chk("unlock", unlock_active, 1);
    chk("start", start_ok, 1);
    ign(1'b1, 140);
    chk("start", start_ok, 0);
    ign(1'b0, 24);
    ign(1'b1, 32);
    repeat (2) begin
      ign(1'b0, 4);
      ign(1'b1, 4);
    end
    ign(1'b1, 32);
    lhkce_partner_i.send_pwd(pwd);
    chk("start", start_ok, 1);
    ign(1'b1, 8);
    ign(1'b0, 26);
    chk("unlock", unlock_active, 1);
    ign(1'b0, 14);
    chk("unlock", unlock_active, 0);
    ign(1'b1, 32);
    chk("entry", entry_active, 1);
    ign(1'b0, 44);
    chk("entry", entry_active, 0);
    enter(pwd ^ 16'h1000);
    chk("lockout", lockout_active, 1);
    chk("unlock", unlock_active, 0);
    ign(1'b1, 32);
    chk("entry", entry_active, 0);
    ce = 1'b0;
    tick(48);
    ce = 1'b1;
    ign(1'b1, 16);
    chk("lockout", lockout_active, 1);
    ign(1'b1, 24);
    chk("lockout", lockout_active, 0);
    pwd_learnt = 1'b0;
    enter(pwd);
    chk("unlock", unlock_active, 0);
    chk("lockout", lockout_active, 0);
    {ecu_learnt, pwd_learnt} = 2'h1;
    enter(pwd);
    chk("unlock", unlock_active, 0);
    chk("lockout", lockout_active, 0);
    ecu_learnt = 1'b1;
    variant_sa = 1'b1;
    tick(4);
    enter(pwd);
    chk("start", start_ok, 1);
    ign(1'b1, 148);
    chk("start", start_ok, 1);
    ign(1'b0, 8);
    chk("unlock", unlock_active, 0);
    chk("start", start_ok, 0);
    for (int sa = 0; sa < 2; sa++) begin
      variant_sa = sa[0];
      tick(6);
      k = $unsigned($random(seed)) % 6;
      flt_type = 2'($random(seed));
      flt_ev = 6'h01 << k;
      tick(1);
      flt_ev = 6'h00;
      tick(1);
      chk("dtc_stb", dtc_stb, 1);
      chk("dtc_code", dtc_code, exp_code(sa[0], k));
      chk("dtc_type", dtc_type, flt_type);
      flt_ev = 6'h3f;
      tick(1);
      flt_ev = 6'h00;
      for (int i = 0; i < 6; i++) begin
        tick(1);
        chk("dtc_stb", dtc_stb, 1);
        chk("dtc_code", dtc_code, exp_code(sa[0], i));
      end
      tick(1);
      chk("dtc_stb", dtc_stb, 0);
    end
    variant_sa = 1'b0;
    tick(4);
    k = stb_cnt;
    for (int i = 0; i < 6; i++) begin
      data_try_fail = (i != 2);
      data_try_ok = (i == 2);
      tick(1);
      data_try_fail = 1'b0;
      data_try_ok = 1'b0;
      tick(3);
      chk("tries", 16'(stb_cnt - k), 16'(i == 5));
    end
    chk("dtc_code", dtc_code, 16'h1805);
    chk("teach", teach_virgin_ok, ecu_virgin);
    key_valid = 1'b1;
    neut_cmd = 1'b1;
    lhkce_partner_i.good_data = 1'b0;
    ign(1'b1, 5);
    chk("nd_req", nd_req, 1);
    ign(1'b1, 7);
    chk("neutral", neutral, 0);
    chk("nd_req", nd_req, 0);
    lhkce_partner_i.good_data = 1'b1;
    ign(1'b0, 8);
    ign(1'b1, 12);
    chk("neutral", neutral, 1);
    chk("nd_req", nd_req, 0);
    chk("teach", teach_virgin_ok, 1);
    twice_on_req = 1'b1;
    ign(1'b1, 32);
    chk("twice_on", twice_on_ok, 0);
    chk("entry", entry_active, 0);
    chk("start", start_ok, 0);
    teach_done = 1'b1;
    tick(1);
    teach_done = 1'b0;
    tick(1);
    chk("neutral", neutral, 0);
    chk("twice_on", twice_on_ok, 1);
    srst = 1'b1;
    nv_lockout = 1'b1;
    tick(4);
    srst = 1'b0;
    tick(3);
    chk("lockout", lockout_active, 1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// file: inc/lhkce_cfg.svh
// timing, code and encoding constants of the limp-home key code entry block
`ifndef LHKCE_CFG_SVH
`define LHKCE_CFG_SVH

// clock rate and timer tick
`define LHKCE_CLK_KHZ 40000
`define LHKCE_TICK_MS 1
`define LHKCE_TICK_CYC (`LHKCE_CLK_KHZ * `LHKCE_TICK_MS)

// times in milliseconds
`define LHKCE_T_ENABLE_MS 5000
`define LHKCE_T_DIGIT_MS 3000
`define LHKCE_T_ABORT_MS 10000
`define LHKCE_T_UNLOCK_MS 30000
`define LHKCE_T_RELOCK_MS 8000
`define LHKCE_T_LOCKOUT_MS 3600000

// counter and password widths
`define LHKCE_TW 22
`define LHKCE_PW 16

// password entry
`define LHKCE_DIGITS 4
`define LHKCE_DIG_W 4
`define LHKCE_ZERO_CYC 4'ha
`define LHKCE_CYC_MAX 4'hf
`define LHKCE_DATA_TRIES 2'h3

// fault sources
`define LHKCE_NFLT 6
`define LHKCE_FLT_TRY 5

// diagnostic codes, transponder-antenna variant
`define LHKCE_DTC_BCM_COMM 16'h1610
`define LHKCE_DTC_ANTENNA 16'h1800
`define LHKCE_DTC_BAD_REQ 16'h1803
`define LHKCE_DTC_XPDR 16'h1801
`define LHKCE_DTC_EEPROM 16'h1801
`define LHKCE_DTC_NO_DATA 16'h1805

// diagnostic codes, stand-alone variant
`define LHKCE_DTC_UNTAUGHT 16'h0001
`define LHKCE_DTC_READ 16'h0002
`define LHKCE_DTC_SID 16'h0003
`define LHKCE_DTC_ANT_OPEN 16'h0004
`define LHKCE_DTC_BODY_INT 16'h0005
`define LHKCE_DTC_NO_ECU 16'h0006

`endif

// file: inc/lhkce_pkg.sv
// types of the limp-home key code entry block
package lhkce_pkg;

  typedef enum logic [1:0] {
    LH_IDLE = 2'b01,
    LH_ENTRY = 2'b10
  } lhkce_lh_st_e;

  typedef enum logic [2:0] {
    NT_IDLE = 3'b001,
    NT_REQ = 3'b010,
    NT_NEUTRAL = 3'b100
  } lhkce_nt_st_e;

  typedef enum logic [1:0] {
    FT_CIRCUIT = 2'h0,
    FT_RANGE = 2'h1,
    FT_LOW = 2'h2,
    FT_HIGH = 2'h3
  } lhkce_ftype_e;

endpackage : lhkce_pkg

// file: rtl/lhkce_core.sv
// limp-home key code entry, unlock window, neutral state and fault codes
`timescale 1ns/1ps
`default_nettype none
`include "lhkce_cfg.svh"

// Overview of operation
// [R01] entry is enabled once ignition has stayed on beyond five seconds
// [R02] ignition on beyond five seconds mid-sequence restarts entry, clearing timers
// [R03] ignition off beyond three seconds closes the digit from counted cycles
// [R04] ignition off beyond ten seconds clears timers and leaves limp-home
// [R05] ten on/off cycles encode the digit zero
// [R06] one to nine cycles since the last digit boundary give that digit
// [R07] unlock for thirty seconds only if unit, password learnt and match
// [R08] antenna variant refuses starting once the unlock window expires
// [R09] each newly entered password restarts the thirty second unlock timer
// [R10] stand-alone variant still permits starting after the window
// [R11] after ignition off, lock when eight seconds elapsed; password needed again
// [R12] stand-alone variant locks at once on ignition off
// [R13] every fault carries one of four types
// [R14] antenna variant reports body reply, antenna, bad request under three codes
// [R15] transponder fault one code; no data after three attempts another
// [R16] stand-alone reports untaught, read error, bad identifier as 01 02 03
// [R17] stand-alone reports open antenna, body internal, no engine unit 04 05 06
// [R18] neutralising requests tester data after ignition on with valid key
// [R19] neutral stays locked and rejects limp-home and twice-ignition-on start
// [R20] neutral unit accepts key teaching like a factory-fresh unit
// [R21] the password is four decimal digits, zero to nine each
// [R22] wrong password blocks limp-home one hour; power loss restarts the hour
module lhkce_core #(
  parameter int TICK_CYC = `LHKCE_TICK_CYC,
  parameter int ENABLE_TK = `LHKCE_T_ENABLE_MS / `LHKCE_TICK_MS,
  parameter int DIGIT_TK = `LHKCE_T_DIGIT_MS / `LHKCE_TICK_MS,
  parameter int ABORT_TK = `LHKCE_T_ABORT_MS / `LHKCE_TICK_MS,
  parameter int UNLOCK_TK = `LHKCE_T_UNLOCK_MS / `LHKCE_TICK_MS,
  parameter int RELOCK_TK = `LHKCE_T_RELOCK_MS / `LHKCE_TICK_MS,
  parameter int LOCKOUT_TK = `LHKCE_T_LOCKOUT_MS / `LHKCE_TICK_MS
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // pins
  input wire logic ign_on,
  input wire logic variant_sa,
  // unit state
  input wire logic ecu_learnt,
  input wire logic ecu_virgin,
  input wire logic pwd_learnt,
  input wire logic [`LHKCE_PW-1:0] stored_pwd,
  input wire logic nv_lockout,
  // neutralising
  input wire logic key_valid,
  input wire logic neut_cmd,
  input wire logic nd_valid,
  input wire logic nd_ok,
  input wire logic teach_done,
  input wire logic twice_on_req,
  // faults
  input wire logic [`LHKCE_NFLT-1:0] flt_ev,
  input wire logic [1:0] flt_type,
  input wire logic data_try_fail,
  input wire logic data_try_ok,
  // status
  output logic entry_active,
  output logic start_ok,
  output logic unlock_active,
  output logic lockout_active,
  output logic nd_req,
  output logic neutral,
  output logic teach_virgin_ok,
  output logic twice_on_ok,
  // diagnostic code report
  output logic dtc_stb,
  output logic [15:0] dtc_code,
  output logic [1:0] dtc_type
);

  localparam int TW = `LHKCE_TW;
  localparam int DW = `LHKCE_DIG_W;
  localparam logic [TW-1:0] ENABLE_L = TW'(ENABLE_TK - 1);
  localparam logic [TW-1:0] DIGIT_L = TW'(DIGIT_TK - 1);
  localparam logic [TW-1:0] ABORT_L = TW'(ABORT_TK - 1);
  localparam logic [TW-1:0] UNLOCK_L = TW'(UNLOCK_TK - 1);
  localparam logic [TW-1:0] RELOCK_L = TW'(RELOCK_TK - 1);
  localparam logic [TW-1:0] LOCKOUT_L = TW'(LOCKOUT_TK - 1);
  localparam logic [TW-1:0] TMAX = '1;
  localparam logic [1:0] LAST_DIG = 2'(`LHKCE_DIGITS - 1);

  logic [1:0] pin_s;
  logic ign_s;
  logic sa_s;
  logic ign_q_ff;
  logic ign_rise;
  logic ign_fall;
  logic [31:0] pre_ff;
  logic tick;
  logic [TW-1:0] on_tk_ff;
  logic [TW-1:0] off_tk_ff;
  logic on_hit;
  logic dig_hit;
  logic abort_hit;
  logic relock_hit;
  lhkce_pkg::lhkce_lh_st_e lh_st_ff;
  lhkce_pkg::lhkce_nt_st_e nt_st_ff;
  logic [DW-1:0] cyc_ff;
  logic [1:0] dig_idx_ff;
  logic [`LHKCE_PW-1:0] pwd_ff;
  logic bad_ff;
  logic [DW-1:0] dig_val;
  logic [`LHKCE_PW-1:0] nxt_pwd;
  logic in_progress;
  logic pwd_done;
  logic pwd_match;
  logic unlock_ff;
  logic unl_exp_ff;
  logic [TW-1:0] unl_tk_ff;
  logic lo_ff;
  logic [TW-1:0] lo_tk_ff;
  logic init_ff;
  logic start_ok_ff;
  logic [1:0] tries_ff;
  logic try_exhaust;
  logic [`LHKCE_NFLT-1:0] flt_src;
  logic [`LHKCE_NFLT-1:0] pend_ff;
  logic [1:0] ptype_ff [`LHKCE_NFLT];
  logic [`LHKCE_NFLT-1:0] pick;
  logic [15:0] pick_code;
  logic [1:0] pick_type;
  logic dtc_stb_ff;
  logic [15:0] dtc_code_ff;
  logic [1:0] dtc_type_ff;

  lhkce_sync #(.W(2)) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .d({variant_sa, ign_on}),
    .q(pin_s)
  );

  assign ign_s = pin_s[0];
  assign sa_s = pin_s[1];
  assign ign_rise = ign_s & ~ign_q_ff;
  assign ign_fall = ~ign_s & ign_q_ff;

  // timer tick prescaler
  always_ff @(posedge clk) begin
    if (srst) begin
      pre_ff <= '0;
    end else if (ce) begin
      pre_ff <= (pre_ff == 32'(TICK_CYC - 1)) ? '0 : pre_ff + 32'h1;
    end
  end

  assign tick = (pre_ff == 32'(TICK_CYC - 1));

  // ignition on and off timers
  always_ff @(posedge clk) begin
    if (srst) begin
      ign_q_ff <= 1'b0;
      on_tk_ff <= '0;
      off_tk_ff <= '0;
    end else if (ce) begin
      ign_q_ff <= ign_s;
      if (ign_rise) begin
        on_tk_ff <= '0;
      end else if (ign_s && tick && on_tk_ff != TMAX) begin
        on_tk_ff <= on_tk_ff + TW'(1);
      end
      if (ign_fall) begin
        off_tk_ff <= '0;
      end else if (!ign_s && tick && off_tk_ff != TMAX) begin
        off_tk_ff <= off_tk_ff + TW'(1);
      end
    end
  end

  assign on_hit = ign_s & ign_q_ff & tick & (on_tk_ff == ENABLE_L);
  assign dig_hit = ~ign_s & ~ign_q_ff & tick & (off_tk_ff == DIGIT_L);
  assign abort_hit = ~ign_s & ~ign_q_ff & tick & (off_tk_ff == ABORT_L);
  assign relock_hit = ~ign_s & ~ign_q_ff & tick & (off_tk_ff == RELOCK_L);

  // digit decoding
  assign dig_val = (cyc_ff == `LHKCE_ZERO_CYC) ? '0 : cyc_ff; // [R05] [R06]
  assign nxt_pwd = {pwd_ff[`LHKCE_PW-DW-1:0], dig_val}; // [R21]
  assign in_progress = (cyc_ff != '0) || (dig_idx_ff != 2'h0);
  assign pwd_done = (lh_st_ff == lhkce_pkg::LH_ENTRY) && dig_hit && (cyc_ff != '0)
                    && (dig_idx_ff == LAST_DIG) && !abort_hit;
  assign pwd_match = !bad_ff && (cyc_ff <= `LHKCE_ZERO_CYC) && (nxt_pwd == stored_pwd);

  // code entry sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      lh_st_ff <= lhkce_pkg::LH_IDLE;
      cyc_ff <= '0;
      dig_idx_ff <= 2'h0;
      pwd_ff <= '0;
      bad_ff <= 1'b0;
    end else if (ce) begin
      unique case (lh_st_ff)
        lhkce_pkg::LH_IDLE: begin
          if (on_hit && !neutral && !lo_ff) begin // [R01] [R19] [R22]
            lh_st_ff <= lhkce_pkg::LH_ENTRY;
            cyc_ff <= '0;
            dig_idx_ff <= 2'h0;
            pwd_ff <= '0;
            bad_ff <= 1'b0;
          end
        end
        lhkce_pkg::LH_ENTRY: begin
          if (abort_hit || neutral) begin // [R04] [R19]
            lh_st_ff <= lhkce_pkg::LH_IDLE;
            cyc_ff <= '0;
            dig_idx_ff <= 2'h0;
            bad_ff <= 1'b0;
          end else if (on_hit && in_progress) begin // [R02]
            cyc_ff <= '0;
            dig_idx_ff <= 2'h0;
            pwd_ff <= '0;
            bad_ff <= 1'b0;
          end else if (ign_fall) begin
            if (cyc_ff != `LHKCE_CYC_MAX) begin
              cyc_ff <= cyc_ff + DW'(1); // [R06]
            end
          end else if (dig_hit && cyc_ff != '0) begin // [R03]
            pwd_ff <= nxt_pwd;
            bad_ff <= bad_ff | (cyc_ff > `LHKCE_ZERO_CYC); // [R21]
            cyc_ff <= '0;
            dig_idx_ff <= dig_idx_ff + 2'h1;
            if (dig_idx_ff == LAST_DIG) begin
              lh_st_ff <= lhkce_pkg::LH_IDLE;
            end
          end
        end
      endcase
    end
  end

  // unlock window and relock
  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_ff <= 1'b0;
      unl_exp_ff <= 1'b0;
      unl_tk_ff <= '0;
    end else if (ce) begin
      if (pwd_done && pwd_match && ecu_learnt && pwd_learnt && !neutral) begin // [R07]
        unlock_ff <= 1'b1;
        unl_exp_ff <= 1'b0;
        unl_tk_ff <= '0; // [R09]
      end else if (neutral || abort_hit) begin // [R19] [R04]
        unlock_ff <= 1'b0;
      end else if (sa_s ? ign_fall : relock_hit) begin // [R12] [R11]
        unlock_ff <= 1'b0;
      end else if (unlock_ff && tick && !unl_exp_ff) begin
        unl_tk_ff <= unl_tk_ff + TW'(1);
        if (unl_tk_ff == UNLOCK_L) begin
          unl_exp_ff <= 1'b1;
        end
      end
    end
  end

  // start permit
  always_ff @(posedge clk) begin
    if (srst) begin
      start_ok_ff <= 1'b0;
    end else if (ce) begin
      start_ok_ff <= unlock_ff && (!unl_exp_ff || sa_s) && !neutral; // [R08] [R10]
    end
  end

  // one-hour refusal after a wrong password
  always_ff @(posedge clk) begin
    if (srst) begin
      lo_ff <= 1'b0;
      lo_tk_ff <= '0;
      init_ff <= 1'b1;
    end else if (ce) begin
      init_ff <= 1'b0;
      if ((init_ff && nv_lockout) || (pwd_done && pwd_learnt && !pwd_match)) begin // [R22]
        lo_ff <= 1'b1;
        lo_tk_ff <= '0;
      end else if (lo_ff && tick) begin
        lo_tk_ff <= lo_tk_ff + TW'(1);
        if (lo_tk_ff == LOCKOUT_L) begin
          lo_ff <= 1'b0;
        end
      end
    end
  end

  // neutralising
  always_ff @(posedge clk) begin
    if (srst) begin
      nt_st_ff <= lhkce_pkg::NT_IDLE;
    end else if (ce) begin
      unique case (nt_st_ff)
        lhkce_pkg::NT_IDLE: begin
          if (ign_rise && key_valid && neut_cmd) begin // [R18]
            nt_st_ff <= lhkce_pkg::NT_REQ;
          end
        end
        lhkce_pkg::NT_REQ: begin
          if (!ign_s) begin
            nt_st_ff <= lhkce_pkg::NT_IDLE;
          end else if (nd_valid) begin
            nt_st_ff <= nd_ok ? lhkce_pkg::NT_NEUTRAL : lhkce_pkg::NT_IDLE; // [R18]
          end
        end
        lhkce_pkg::NT_NEUTRAL: begin
          if (teach_done) begin // [R20]
            nt_st_ff <= lhkce_pkg::NT_IDLE;
          end
        end
      endcase
    end
  end

  assign neutral = (nt_st_ff == lhkce_pkg::NT_NEUTRAL);
  assign nd_req = (nt_st_ff == lhkce_pkg::NT_REQ);
  assign teach_virgin_ok = ecu_virgin | neutral; // [R20]
  assign twice_on_ok = twice_on_req & ~neutral; // [R19]

  // data attempt counter
  always_ff @(posedge clk) begin
    if (srst) begin
      tries_ff <= 2'h0;
    end else if (ce) begin
      if (data_try_ok || try_exhaust) begin
        tries_ff <= 2'h0;
      end else if (data_try_fail) begin
        tries_ff <= tries_ff + 2'h1;
      end
    end
  end

  assign try_exhaust = data_try_fail && (tries_ff == `LHKCE_DATA_TRIES - 2'h1); // [R15]
  assign flt_src = flt_ev | (`LHKCE_NFLT'(try_exhaust & ~sa_s) << `LHKCE_FLT_TRY);

  // pending fault per source, raise wins over report
  for (genvar i = 0; i < `LHKCE_NFLT; i++) begin : g_flt
    always_ff @(posedge clk) begin
      if (srst) begin
        pend_ff[i] <= 1'b0;
        ptype_ff[i] <= 2'h0;
      end else if (ce) begin
        if (flt_src[i]) begin
          pend_ff[i] <= 1'b1;
          ptype_ff[i] <= flt_type; // [R13]
        end else if (pick[i]) begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // lowest pending source is reported first
  always_comb begin
    pick = '0;
    pick_type = 2'h0;
    pick_code = 16'h0000;
    for (int i = `LHKCE_NFLT - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        pick = `LHKCE_NFLT'(1) << i;
        pick_type = ptype_ff[i];
        unique case (i)
          0: pick_code = sa_s ? `LHKCE_DTC_UNTAUGHT : `LHKCE_DTC_BCM_COMM; // [R14] [R16]
          1: pick_code = sa_s ? `LHKCE_DTC_READ : `LHKCE_DTC_ANTENNA; // [R14] [R16]
          2: pick_code = sa_s ? `LHKCE_DTC_SID : `LHKCE_DTC_BAD_REQ; // [R14] [R16]
          3: pick_code = sa_s ? `LHKCE_DTC_ANT_OPEN : `LHKCE_DTC_XPDR; // [R15] [R17]
          4: pick_code = sa_s ? `LHKCE_DTC_BODY_INT : `LHKCE_DTC_EEPROM; // [R17]
          default: pick_code = sa_s ? `LHKCE_DTC_NO_ECU : `LHKCE_DTC_NO_DATA; // [R15] [R17]
        endcase
      end
    end
  end

  // registered fault report
  always_ff @(posedge clk) begin
    if (srst) begin
      dtc_stb_ff <= 1'b0;
      dtc_code_ff <= 16'h0000;
      dtc_type_ff <= 2'h0;
    end else if (ce) begin
      dtc_stb_ff <= |pick;
      if (|pick) begin
        dtc_code_ff <= pick_code;
        dtc_type_ff <= pick_type; // [R13]
      end
    end
  end

  assign entry_active = (lh_st_ff == lhkce_pkg::LH_ENTRY) && !neutral; // [R19]
  assign start_ok = start_ok_ff;
  assign unlock_active = unlock_ff;
  assign lockout_active = lo_ff;
  assign dtc_stb = dtc_stb_ff;
  assign dtc_code = dtc_code_ff;
  assign dtc_type = dtc_type_ff;

endmodule : lhkce_core

`default_nettype wire

// file: rtl/lhkce_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none

module lhkce_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : lhkce_sync

`default_nettype wire
